// ==== src/flash_front_pkg.sv ====
// constants and types for the serial flash power-up and spi front end
// How it works
// RULE1: mode 3 is assumed after any reset
// RULE2: data output stays undriven after reset
// RULE3: decoding starts only after a select falling edge
// RULE4: clock idle level at select fall picks mode
// RULE5: host waits 70 us before first select
// RULE6: reset held means every command is ignored
// RULE7: reset release lands the front in standby
// RULE8: program or erase waits up to 3 ms
// RULE9: address bits are page, byte or dummy
// RULE10: inactive select ignores clock, input; output undriven
package flash_front_pkg;
  // core clock rate
  localparam int CLK_MHZ = 200;
  // host hold-off after supply valid, in microseconds
  localparam int SUPPLY_TO_SELECT_HOLDOFF_US = 70;
  // least time rounds up to whole cycles
  localparam int HOLDOFF_CYCLES = SUPPLY_TO_SELECT_HOLDOFF_US * CLK_MHZ;
  // delay before a first program or erase, in microseconds
  localparam int FIRST_WRITE_DELAY_US = 3000;
  // longest time rounds down to whole cycles
  localparam int FIRST_WRITE_CYCLES = FIRST_WRITE_DELAY_US * CLK_MHZ;
  // width of the first-write counter
  localparam int FW_W = 20;
  // serial word width
  localparam int BYTE_W = 8;
  // bit counter width inside one byte
  localparam int BIT_W = 3;
  // mode after reset: 1 means mode 3 (clock idles high)
  localparam logic MODE3_AFTER_RESET = 1'b1;
  // front states, gray along standby -> active -> standby
  typedef enum logic [1:0]
  {
    STANDBY = 2'b00,
    ACTIVE = 2'b01
  } front_state_e;
endpackage

// ==== src/link_byte_if.sv ====
// byte hand-over from the serial clock domain to the core domain
`timescale 1ns/10ps
`default_nettype none
interface link_byte_if;
  // last complete byte, stable until the next one completes
  logic [flash_front_pkg::BYTE_W-1:0] data;
  // flips once per completed byte
  logic toggle;
  modport src (output data, output toggle);
  modport dst (input data, input toggle);
endinterface
`default_nettype wire

// ==== src/serial_flash_powerup_spi_front.sv ====
// power-up state, mode detection and command front end of the serial flash
`timescale 1ns/10ps
`default_nettype none
module serial_flash_powerup_spi_front
  import flash_front_pkg::*;
#(
  // shorten in simulation; default is the full first-write delay
  parameter int FIRST_WRITE_CYCLES_P = FIRST_WRITE_CYCLES
)
(
  // core clock and reset (reset stands for power-on or reset condition)
  input wire logic clk,
  input wire logic srst,
  // spi pins from the host
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  // serial data output pin, split into value and enable
  output logic so_out,
  output logic so_oe,
  // request from the core to drive the output pin
  input wire logic drive_req,
  input wire logic drive_bit,
  // received bytes toward the command decoder
  output logic [BYTE_W-1:0] rx_byte,
  output logic rx_valid,
  output logic rx_first,
  // status toward the core
  output logic mode3,
  output logic frame_active,
  output logic write_allowed
);
  import flash_front_pkg::*;

  // all core-domain state in one record
  typedef struct packed {
    front_state_e state;
    logic cs_s1;
    logic cs_s2;
    logic cs_prev;
    logic sck_s1;
    logic sck_s2;
    logic tg_s1;
    logic tg_s2;
    logic tg_prev;
    logic mode3;
    logic first_pending;
    logic [BYTE_W-1:0] rx_byte;
    logic rx_valid;
    logic rx_first;
    logic [FW_W-1:0] fw_cnt;
    logic fw_done;
    logic so_out;
    logic so_oe;
  } front_s;

  front_s st;
  front_s next_st;
  // edges seen on synchronised select
  logic cs_fall;
  logic cs_rise;
  // new byte announced by the link domain
  logic byte_evt;

  link_byte_if lb ();

  // link-side shifter on the host clock
  serial_shifter u_shift (
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .srst(srst),
    .out(lb.src)
  );

  // edge detectors read the second sync stage and its delayed copy, never the first
  assign cs_fall = st.cs_prev & ~st.cs_s2;
  assign cs_rise = ~st.cs_prev & st.cs_s2;
  assign byte_evt = st.tg_s2 ^ st.tg_prev;

  // next-state logic
  always_comb
  begin
    next_st = st;
    // two-stage synchronisers for pins and the byte toggle
    next_st.cs_s1 = cs_n;
    next_st.cs_s2 = st.cs_s1;
    next_st.cs_prev = st.cs_s2;
    next_st.sck_s1 = sck;
    next_st.sck_s2 = st.sck_s1;
    next_st.tg_s1 = lb.toggle;
    next_st.tg_s2 = st.tg_s1;
    next_st.tg_prev = st.tg_s2;
    next_st.rx_valid = 1'b0;
    next_st.rx_first = 1'b0;
    // first-write delay counts from reset release and then sticks
    if (!st.fw_done)
    begin
      next_st.fw_cnt = st.fw_cnt + FW_W'(1);
      next_st.fw_done = (st.fw_cnt == FW_W'(FIRST_WRITE_CYCLES_P - 1)); // RULE8
    end
    case (st.state)
      STANDBY:
      begin
        // only a real high-to-low select edge opens a frame
        if (cs_fall) // RULE3
        begin
          next_st.state = ACTIVE;
          // clock idling high means mode 3, low means mode 0
          next_st.mode3 = st.sck_s2; // RULE4
          next_st.first_pending = 1'b1;
        end
      end
      ACTIVE:
      begin
        if (byte_evt)
        begin
          // bytes are forwarded only inside a frame
          next_st.rx_byte = lb.data;
          next_st.rx_valid = 1'b1;
          next_st.rx_first = st.first_pending;
          next_st.first_pending = 1'b0;
        end
        // select rising ends the frame, back to standby
        if (cs_rise)
          next_st.state = STANDBY; // RULE10
      end
      default:
      begin
        next_st.state = STANDBY;
      end
    endcase
    // output pin driven only in a frame and only on request
    next_st.so_oe = (st.state == ACTIVE) && !st.cs_s2 && drive_req; // RULE2 RULE10
    next_st.so_out = drive_bit;
  end

  // register; reset disables everything and lands in standby
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st <= '0; // RULE6 RULE7
      st.state <= STANDBY; // RULE7
      st.mode3 <= MODE3_AFTER_RESET; // RULE1
    end
    else
      st <= next_st;
  end

  // outputs come straight from flip-flops, except frame_active, which is decoded from the state
  assign so_out = st.so_out;
  assign so_oe = st.so_oe;
  assign rx_byte = st.rx_byte;
  assign rx_valid = st.rx_valid;
  assign rx_first = st.rx_first;
  assign mode3 = st.mode3;
  assign frame_active = (st.state == ACTIVE);
  assign write_allowed = st.fw_done;

  // host hold-off is not checked here; the host must keep select high long enough // RULE5
  // a select that falls too early is simply taken as a normal frame

  // reset always leaves mode 3 behind
  reset_mode_a: assert property (@(posedge clk) srst |=> st.mode3) // RULE1
    else $error("mode is not 3 after reset");
  // the output is driven only after an active cycle
  so_quiet_a: assert property (@(posedge clk) disable iff (srst) // RULE2
    st.so_oe |-> ($past(st.state) == ACTIVE) && !$past(st.cs_s2))
    else $error("output driven outside a frame");
  // standby holds until a select fall
  start_fall_a: assert property (@(posedge clk) disable iff (srst) // RULE3
    (st.state == STANDBY) && !cs_fall |=> (st.state == STANDBY))
    else $error("frame opened without select fall");
  // mode follows sampled clock idle level
  mode_pick_a: assert property (@(posedge clk) disable iff (srst) // RULE4
    (st.state == STANDBY) && cs_fall |=> (st.mode3 == $past(st.sck_s2)))
    else $error("mode not taken from clock idle level");
  // mode stays put for the whole frame
  mode_hold_a: assert property (@(posedge clk) disable iff (srst) // RULE4
    (st.state == ACTIVE) |=> (st.mode3 == $past(st.mode3)))
    else $error("mode changed inside a frame");
  // nothing is accepted while reset is held
  reset_ignore_a: assert property (@(posedge clk) // RULE6
    srst |=> !st.rx_valid && !st.so_oe && (st.state == STANDBY))
    else $error("activity during reset");
  // standby and no frame in the first cycle after release
  standby_after_a: assert property (@(posedge clk) // RULE7
    $fell(srst) |-> (st.state == STANDBY) && !frame_active)
    else $error("not in standby after reset");
  // write permission rises exactly at the end of the delay
  write_gate_a: assert property (@(posedge clk) disable iff (srst) // RULE8
    $rose(st.fw_done) |-> ($past(st.fw_cnt) == FW_W'(FIRST_WRITE_CYCLES_P - 1)))
    else $error("first write allowed at the wrong time");
  // write permission never falls back without a reset
  write_hold_a: assert property (@(posedge clk) disable iff (srst) // RULE8
    st.fw_done |=> st.fw_done)
    else $error("write permission dropped");
  // bytes delivered only out of an active frame
  byte_frame_a: assert property (@(posedge clk) disable iff (srst) // RULE9
    st.rx_valid |-> ($past(st.state) == ACTIVE) && ($past(byte_evt)))
    else $error("byte delivered outside a frame");
  // inactive select keeps standby silent; a frame opening may drive one cycle later
  idle_ignore_a: assert property (@(posedge clk) disable iff (srst) // RULE10
    (st.state == STANDBY) |=> !st.rx_valid && !st.so_oe)
    else $error("activity while select inactive");
  // select rise always closes the frame
  frame_close_a: assert property (@(posedge clk) disable iff (srst) // RULE10
    (st.state == ACTIVE) && cs_rise |=> (st.state == STANDBY))
    else $error("frame kept open after select rise");

  // main scenarios
  mode0_c: cover property (@(posedge clk) disable iff (srst)
    (st.state == STANDBY) && cs_fall && !st.sck_s2);
  mode3_c: cover property (@(posedge clk) disable iff (srst)
    (st.state == STANDBY) && cs_fall && st.sck_s2);
  opcode_c: cover property (@(posedge clk) disable iff (srst) st.rx_valid && st.rx_first);
  write_ok_c: cover property (@(posedge clk) disable iff (srst) $rose(st.fw_done));
  // a frame ended by a select rise
  close_c: cover property (@(posedge clk) disable iff (srst) (st.state == ACTIVE) && cs_rise);
endmodule // serial_flash_powerup_spi_front
`default_nettype wire

// ==== src/serial_shifter.sv ====
// serial clock domain shifter that assembles input bits into bytes
`timescale 1ns/10ps
`default_nettype none
module serial_shifter
  import flash_front_pkg::*;
(
  // link clock and frame
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  // core reset, used as an asynchronous clear here
  input wire logic srst,
  // byte hand-over
  link_byte_if.src out
);
  // per-frame part, cleared whenever select is inactive
  typedef struct packed {
    logic [BYTE_W-2:0] shift;
    logic [BIT_W-1:0] cnt;
  } frame_s;
  // hand-over part, survives between frames
  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic toggle;
  } hold_s;
  frame_s fr;
  frame_s next_fr;
  hold_s hd;
  hold_s next_hd;
  // clear asserts with select high, so no stale bit count leaks into a frame
  logic frame_clr;
  assign frame_clr = cs_n | srst; // RULE10

  // both modes sample input on the rising clock edge
  always_comb
  begin
    next_fr = fr;
    next_hd = hd;
    next_fr.shift = {fr.shift[BYTE_W-3:0], si};
    next_fr.cnt = fr.cnt + 3'(1);
    // eighth bit completes a byte; dummy bits pass on unchanged
    if (fr.cnt == 3'(BYTE_W - 1))
    begin
      next_hd.data = {fr.shift, si}; // RULE9
      next_hd.toggle = ~hd.toggle;
    end
  end

  // frame state, async clear to constants only
  always_ff @(posedge sck or posedge frame_clr)
  begin
    if (frame_clr)
      fr <= '0;
    else
      fr <= next_fr;
  end

  // hand-over state; data is held for a whole byte time, far longer than the sync
  always_ff @(posedge sck or posedge srst)
  begin
    if (srst)
      hd <= '0;
    else
      hd <= next_hd;
  end

  assign out.data = hd.data;
  assign out.toggle = hd.toggle;
endmodule // serial_shifter
`default_nettype wire

// ==== verification/spi_host_model.sv ====
// behavioural spi host that drives select, clock and data into the front end
`timescale 1ns/10ps
`default_nettype none
module spi_host_model
  import flash_front_pkg::*;
(
  // spi pins toward the device
  output logic sck,
  output logic cs_n,
  output logic si
);
  // pins idle with select released and the clock parked high
  initial
  begin
    sck = 1'b1;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // wait out the supply hold-off before any select; core clock is 5 ns
  task automatic holdoff();
    #(SUPPLY_TO_SELECT_HOLDOFF_US * 1000);
  endtask

  // park the clock at its idle level, then make the select fall
  task automatic open_frame(input logic idle);
    sck = idle;
    #40;
    cs_n = 1'b0;
    #40;
  endtask

  // msb first, 32 ns bit period; clock parks again afterwards
  task automatic send_byte(input logic [7:0] b, input int nbits);
    logic idle;
    idle = sck;
    for (int i = 0; i < nbits; i++)
    begin
      sck = 1'b0;
      si = b[7-i];
      #16;
      sck = 1'b1;
      #16;
    end
    // released data shows the inverse, never the last bit
    si = ~si;
    sck = idle;
    #16;
  endtask

  // select rises and stays up long enough to be seen
  task automatic close_frame();
    #40;
    cs_n = 1'b1;
    #40;
  endtask
endmodule // spi_host_model
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the serial flash power-up front end
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end
module tb;
  import flash_front_pkg::*;
  // short first-write count keeps the run brief
  localparam int FW_CYC = 64;
  logic clk = 1'b0;
  logic srst = 1'b1;
  wire sck;
  wire cs_n;
  wire si;
  logic drive_req = 1'b0;
  logic drive_bit = 1'b0;
  logic so_out, so_oe, rx_valid, rx_first, mode3, frame_active, write_allowed;
  logic [BYTE_W-1:0] rx_byte;
  logic [BYTE_W-1:0] got_byte = '0;
  logic got_first = 1'b0;
  int n_rx = 0;
  int n_errors = 0;
  int checks_done = 0;

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  spi_host_model host (.sck(sck), .cs_n(cs_n), .si(si));

  serial_flash_powerup_spi_front #(.FIRST_WRITE_CYCLES_P(FW_CYC))
    i_serial_flash_powerup_spi_front (.clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n),
    .si(si), .so_out(so_out), .so_oe(so_oe), .drive_req(drive_req), .drive_bit(drive_bit),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_first(rx_first), .mode3(mode3),
    .frame_active(frame_active), .write_allowed(write_allowed));

  // capture every delivered byte, since the strobe stands one cycle
  always @(posedge clk)
    if (rx_valid === 1'b1)
    begin
      n_rx <= n_rx + 1;
      got_byte <= rx_byte;
      got_first <= rx_first;
    end

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // reset with traffic during it, then release checks and first-write count
  task automatic do_reset();
    int base;
    @(posedge clk);
    #1 srst = 1'b1;
    base = n_rx;
    host.open_frame(1'b0);
    host.send_byte(8'h3c, 8);
    host.close_frame();
    `CHK("rx count in reset", base, n_rx)
    `CHK("frame in reset", 1'b0, frame_active)
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
    @(posedge clk);
    #1;
    `CHK("mode after reset", MODE3_AFTER_RESET, mode3)
    `CHK("so enable after reset", 1'b0, so_oe)
    `CHK("frame after reset", 1'b0, frame_active)
    repeat (FW_CYC - 4) @(posedge clk);
    `CHK("write allowed early", 1'b0, write_allowed)
    repeat (8) @(posedge clk);
    `CHK("write allowed late", 1'b1, write_allowed)
    host.holdoff();
  endtask

  // two bytes in one frame with a chosen clock idle level
  task automatic t_frame(input logic idle, input logic [7:0] b0, input logic [7:0] b1);
    int base;
    base = n_rx;
    host.open_frame(idle);
    `CHK("mode at select fall", idle, mode3)
    `CHK("frame open", 1'b1, frame_active)
    host.send_byte(b0, 8);
    repeat (8) @(posedge clk);
    `CHK("first byte", b0, got_byte)
    `CHK("first flag", 1'b1, got_first)
    host.send_byte(b1, 8);
    repeat (8) @(posedge clk);
    `CHK("second byte", b1, got_byte)
    `CHK("second flag", 1'b0, got_first)
    `CHK("byte count", base + 2, n_rx)
    host.close_frame();
    `CHK("frame closed", 1'b0, frame_active)
  endtask

  // output enable is refused outside a frame and follows the request inside
  task automatic t_drive();
    @(posedge clk);
    #1 drive_req = 1'b1;
    drive_bit = 1'b1;
    repeat (4) @(posedge clk);
    `CHK("so enable idle", 1'b0, so_oe)
    host.open_frame(1'b1);
    `CHK("so enable in frame", 1'b1, so_oe)
    `CHK("so value high", 1'b1, so_out)
    @(posedge clk);
    #1 drive_bit = 1'b0;
    repeat (2) @(posedge clk);
    `CHK("so value low", 1'b0, so_out)
    #1 drive_req = 1'b0;
    repeat (2) @(posedge clk);
    `CHK("so enable dropped", 1'b0, so_oe)
    host.close_frame();
  endtask

  // partial byte then stray clocks with select high must leave nothing behind
  task automatic t_partial();
    int base;
    base = n_rx;
    host.open_frame(1'b0);
    host.send_byte(8'hff, 4);
    host.close_frame();
    host.send_byte(8'h55, 8);
    repeat (8) @(posedge clk);
    `CHK("no byte outside frame", base, n_rx)
    host.open_frame(1'b1);
    host.send_byte(8'h81, 8);
    repeat (8) @(posedge clk);
    `CHK("byte after abort", 8'h81, got_byte)
    `CHK("flag after abort", 1'b1, got_first)
    host.close_frame();
  endtask

  // main sequence, with a second reset in mid-run after a mode 0 frame
  initial
  begin
    do_reset();
    t_frame(1'b0, 8'ha5, 8'h3c);
    t_frame(1'b1, 8'h0f, 8'hd2);
    t_drive();
    t_partial();
    t_frame(1'b0, 8'h81, 8'h7e);
    do_reset();
    t_frame(1'b1, 8'hc3, 8'h01);
    conclude();
  end

  // watchdog: the sequence needs about 150 us
  initial
  begin
    #400000;
    n_errors++;
    conclude();
  end
endmodule // tb
`default_nettype wire
